// *** pec_log_page.sv ***
`timescale 1ns/1ps
`include "pec_defines.svh"
module pec_log_page
  import pec_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  // Link events on this clock: link-up state is a level, the rest are one-cycle pulses from link logic
  input  wire logic        phy_link_up_state_in,
  input  wire logic        sig_fis_rok_in,
  input  wire logic        rx_rerr_crc_in,
  input  wire logic        rx_rerr_other_in,
  input  wire logic        bist_activate_in,
  // Log read request
  input  wire logic        read_req_in,
  input  wire logic        read_clear_in,
  output logic             read_busy_out,
  // Byte stream to the host
  output logic             byte_valid_out,
  input  wire logic        byte_ready_in,
  output logic [7:0]       byte_data_out,
  output logic             byte_last_out
);
  // ------------------------------------------------------------
  // Counters
  // ------------------------------------------------------------
  logic                  link_up_reg;
  logic                  link_up_next;
  logic [`PEC_NUM_CNT-1:0] ev;
  logic                  clear_all;
  logic [`PEC_CNT_W-1:0] cnt [`PEC_NUM_CNT];

  pec_state_e            state_reg;
  pec_state_e            state_next;
  logic [8:0]            idx_reg;
  logic [8:0]            idx_next;
  logic [7:0]            sum_reg;
  logic [7:0]            sum_next;
  logic                  clr_pend_reg;
  logic                  clr_pend_next;
  logic [7:0]            data_reg;
  logic [7:0]            data_next;
  logic                  valid_reg;
  logic                  valid_next;
  logic                  last_reg;
  logic                  last_next;
  logic                  send_done;

  // Power-management wake-ups are counted too, which is allowed.
  assign ev[`PEC_IDX_LINKUP] = phy_link_up_state_in && !link_up_reg; // [R1] [R2]
  assign ev[`PEC_IDX_SIGFIS] = sig_fis_rok_in;   // [R3]
  assign ev[`PEC_IDX_CRCERR] = rx_rerr_crc_in;   // [R4]
  assign ev[`PEC_IDX_OTHERR] = rx_rerr_other_in; // [R5]

  assign send_done = (state_reg == PEC_SUM) && byte_ready_in;
  assign clear_all = bist_activate_in || (send_done && clr_pend_reg); // [R15] [R16]

  for (genvar g = 0; g < `PEC_NUM_CNT; g++) begin : g_cnt
    pec_counter u_cnt (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .event_in   (ev[g]),
      .clear_in   (clear_all),
      .count_out  (cnt[g])
    );
  end

  // ------------------------------------------------------------
  // Link-up edge detect
  // ------------------------------------------------------------
  // Level from the link state machine; a rising edge is one transition.
  // Resets to the link-down level, so a link already up at reset release counts as one edge.
  always_comb begin
    link_up_next = phy_link_up_state_in;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link_up_reg <= 1'b0;
    end else begin
      link_up_reg <= link_up_next;
    end
  end

  // ------------------------------------------------------------
  // Page layout
  // ------------------------------------------------------------
  function automatic logic [15:0] ident(input logic [1:0] i);
    case (i)
      `PEC_IDX_LINKUP: ident = `PEC_ID_LINKUP;
      `PEC_IDX_SIGFIS: ident = `PEC_ID_SIGFIS;
      `PEC_IDX_CRCERR: ident = `PEC_ID_CRCERR;
      default:         ident = `PEC_ID_OTHERR;
    endcase
  endfunction : ident

  // Saturated narrow counter is one-extended over the whole field, so the
  // host never mistakes a stuck counter for a small count.
  function automatic logic [15:0] report_value(input logic [`PEC_CNT_W-1:0] c);
    report_value = (c == `PEC_CNT_MAX) ? 16'hFFFF : {8'h00, c}; // [R11] [R18]
  endfunction : report_value

  // Every entry is a 16-bit id plus a 16-bit value; ids carry width code 1h.
  // Vendor ids would keep the same bits 14:12 encoding.
  function automatic pec_byte_t page_byte(input logic [8:0] a,
                                          input logic [`PEC_CNT_W-1:0] c0,
                                          input logic [`PEC_CNT_W-1:0] c1,
                                          input logic [`PEC_CNT_W-1:0] c2,
                                          input logic [`PEC_CNT_W-1:0] c3);
    logic [8:0]  rel;
    logic [1:0]  ent;
    logic [15:0] id;
    logic [15:0] val;
    logic [`PEC_CNT_W-1:0] c;
    rel = a - `PEC_HDR_BYTES;
    ent = rel[3:2];
    id  = ident(ent);
    case (ent)
      2'h0:    c = c0;
      2'h1:    c = c1;
      2'h2:    c = c2;
      default: c = c3;
    endcase
    val = report_value(c); // [R9] [R17]
    page_byte = 8'h00; // [R7] [R10]
    if ((a >= `PEC_HDR_BYTES) &&
        (a < 9'(`PEC_HDR_BYTES + `PEC_ENTRY_BYTES * `PEC_NUM_CNT))) begin
      case (rel[1:0])
        2'h0:    page_byte = id[7:0];   // [R8]
        2'h1:    page_byte = id[15:8];
        2'h2:    page_byte = val[7:0];
        default: page_byte = val[15:8];
      endcase
    end
  endfunction : page_byte

  // ------------------------------------------------------------
  // Read sequencer
  // ------------------------------------------------------------
  // Bytes go out little-endian in address order; the current byte is
  // registered so the data output never glitches while stalled.
  always_comb begin
    state_next    = state_reg;
    idx_next      = idx_reg;
    sum_next      = sum_reg;
    clr_pend_next = clr_pend_reg;
    data_next     = data_reg;
    valid_next    = valid_reg;
    last_next     = last_reg;
    case (state_reg)
      PEC_IDLE: begin
        if (read_req_in) begin
          state_next    = PEC_SEND;
          idx_next      = '0;
          sum_next      = '0;
          clr_pend_next = read_clear_in;
          data_next     = page_byte(9'h000, cnt[0], cnt[1], cnt[2], cnt[3]);
          valid_next    = 1'b1;
        end
      end
      PEC_SEND: begin
        if (byte_ready_in) begin
          sum_next = sum_reg + data_reg; // [R13]
          idx_next = idx_reg + 1'b1;
          if (idx_next == `PEC_LAST_BYTE) begin
            state_next = PEC_SUM;
            data_next  = 8'(~sum_next + 1'b1); // [R13]
            last_next  = 1'b1;
          end else begin
            data_next = page_byte(idx_next, cnt[0], cnt[1], cnt[2], cnt[3]);
          end
        end
      end
      PEC_SUM: begin
        if (byte_ready_in) begin
          state_next    = PEC_IDLE; // [R6]
          valid_next    = 1'b0;
          data_next     = '0;
          clr_pend_next = 1'b0;
          last_next     = 1'b0;
        end
      end
      default: begin
        state_next = PEC_IDLE;
        valid_next = 1'b0;
        last_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg    <= PEC_IDLE;
      idx_reg      <= '0;
      sum_reg      <= '0;
      clr_pend_reg <= 1'b0;
      data_reg     <= '0;
      valid_reg    <= 1'b0;
      last_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      idx_reg      <= idx_next;
      sum_reg      <= sum_next;
      clr_pend_reg <= clr_pend_next;
      data_reg     <= data_next;
      valid_reg    <= valid_next;
      last_reg     <= last_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Counters keep running during a read; a later byte may show a newer value
  // than an earlier one, so the checksum is taken over the bytes as sent.
  assign byte_valid_out = valid_reg;
  assign byte_data_out  = data_reg;
  assign byte_last_out  = last_reg;
  assign read_busy_out  = (state_reg != PEC_IDLE);
endmodule : pec_log_page

// *** pec_defines.svh ***
`ifndef PEC_DEFINES_SVH
`define PEC_DEFINES_SVH
// Function
// R1: Count every entry into phy_link_up_state from phy_link_down_state, any cause.
// R2: Power-management transitions may also be counted; no exclusion is done.
// R3: Count reset-signature register FISes sent after COMRESET and acknowledged by R_OK.
// R4: Count received host FISes answered with R_ERR because of CRC error.
// R5: Count received host FISes answered with R_ERR for non-CRC reasons.
// R6: Counter log page is exactly 512 bytes; first dword covers the page.
// R7: All reserved fields, bytes 0-3 and 508-510, read as zero.
// R8: Each entry opens with a 16-bit identifier, value directly following.
// R9: Value field length comes from identifier bits 14:12, multiple of 16 bits.
// R10: Entry list ends with identifier 0h; nothing valid follows it.
// R11: A narrower counter at maximum reports all upper bits one.
// R12: Counters saturate at maximum and never wrap to zero.
// R13: Last byte is two's complement of the byte sum of 511 bytes.
// R14: Host parses entries in order until identifier 0h or page end.
// R15: A received BIST Activate FIS resets every counter.
// R16: Reading page 11h with Features bit 0 set returns values, then clears.
// R17: Identifier bits 14:12: 1h 16, 2h 32, 3h 48, 4h 64 bits.
// R18: Bit 15 identifiers are vendor specific but keep the width encoding.
// R19: All counters start at zero after power-on reset.
`define PEC_PAGE_BYTES   10'h200
`define PEC_LAST_BYTE    9'h1FF
`define PEC_HDR_BYTES    9'h004
`define PEC_ENTRY_BYTES  9'h004
`define PEC_NUM_CNT      3'h4
`define PEC_CNT_W        8
`define PEC_CNT_MAX      8'hFF
`define PEC_ID_LINKUP    16'h1009
`define PEC_ID_SIGFIS    16'h100A
`define PEC_ID_CRCERR    16'h100B
`define PEC_ID_OTHERR    16'h100D
`define PEC_ID_END       16'h0000
`define PEC_IDX_LINKUP   2'h0
`define PEC_IDX_SIGFIS   2'h1
`define PEC_IDX_CRCERR   2'h2
`define PEC_IDX_OTHERR   2'h3
`endif

// *** pec_pkg.sv ***
package pec_pkg;
  typedef enum logic [1:0] {
    PEC_IDLE,
    PEC_SEND,
    PEC_SUM
  } pec_state_e;
  typedef logic [7:0] pec_byte_t;
endpackage : pec_pkg

// *** pec_counter.sv ***
`timescale 1ns/1ps
`include "pec_defines.svh"
module pec_counter
  import pec_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_b_in,
  // Control
  input  wire logic                 event_in,
  input  wire logic                 clear_in,
  // Value
  output logic [`PEC_CNT_W-1:0]     count_out
);
  logic [`PEC_CNT_W-1:0] count_reg;
  logic [`PEC_CNT_W-1:0] count_next;

  // Clear wins over an event in the same cycle; a clearing read also loses every event
  // counted after it sent this counter's bytes, up to its checksum byte.
  always_comb begin
    count_next = count_reg;
    if (clear_in) begin
      count_next = '0; // [R15] [R16]
    end else if (event_in && (count_reg != `PEC_CNT_MAX)) begin
      count_next = count_reg + 1'b1; // [R12]
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_reg <= '0; // [R19]
    end else begin
      count_reg <= count_next;
    end
  end

  assign count_out = count_reg;
endmodule : pec_counter

// *** pec_log_page_props.sv ***
`timescale 1ns/1ps
module pec_log_page_props (
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       rst_b_in,
  // Events and request
  input wire logic       phy_link_up_state_in,
  input wire logic       sig_fis_rok_in,
  input wire logic       rx_rerr_crc_in,
  input wire logic       rx_rerr_other_in,
  input wire logic       bist_activate_in,
  input wire logic       read_req_in,
  input wire logic       read_clear_in,
  // Byte stream
  input wire logic       read_busy_out,
  input wire logic       byte_valid_out,
  input wire logic       byte_ready_in,
  input wire logic [7:0] byte_data_out,
  input wire logic       byte_last_out
);
  logic [8:0] idx_reg;
  logic [7:0] sum_reg;
  wire        take = byte_valid_out && byte_ready_in;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idx_reg <= 9'h000;
      sum_reg <= 8'h00;
    end else if (!read_busy_out) begin
      idx_reg <= 9'h000;
      sum_reg <= 8'h00;
    end else if (take) begin
      idx_reg <= idx_reg + 9'h001;
      sum_reg <= sum_reg + byte_data_out;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_req;
    read_req_in && !read_busy_out;
  endsequence
  sequence s_first;
    read_busy_out && byte_valid_out && byte_data_out == 8'h00;
  endsequence
  property p_answer; s_req |=> s_first; endproperty
  a_answer: assert property (p_answer) else $error("first byte late or nonzero");
  property p_hold; byte_valid_out && !byte_ready_in |=> byte_valid_out && $stable(byte_data_out); endproperty
  a_hold: assert property (p_hold) else $error("byte dropped before taken");
  property p_last; byte_valid_out |-> byte_last_out == (idx_reg == 9'h1FF); endproperty
  a_last: assert property (p_last) else $error("last flag at wrong byte");
  property p_end; take && byte_last_out |=> !byte_valid_out && !read_busy_out; endproperty
  a_end: assert property (p_end) else $error("page longer than 512 bytes");
  property p_sum; take && byte_last_out |-> 8'(sum_reg + byte_data_out) == 8'h00; endproperty
  a_sum: assert property (p_sum) else $error("page sum not zero");
  property p_zero; byte_valid_out && idx_reg >= 9'h014 && idx_reg < 9'h1FF |-> byte_data_out == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("nonzero after terminator");
  property p_id; byte_valid_out && idx_reg[1:0] == 2'h1 && idx_reg > 9'h004 && idx_reg < 9'h014
    |-> byte_data_out == 8'h10; endproperty
  a_id: assert property (p_id) else $error("identifier width code wrong");
  property p_idle; !read_busy_out |-> !byte_valid_out; endproperty
  a_idle: assert property (p_idle) else $error("byte offered while idle");
endmodule : pec_log_page_props
bind pec_log_page pec_log_page_props u_props (
  .clk_sys_in           (clk_sys_in),
  .rst_b_in             (rst_b_in),
  .phy_link_up_state_in (phy_link_up_state_in),
  .sig_fis_rok_in       (sig_fis_rok_in),
  .rx_rerr_crc_in       (rx_rerr_crc_in),
  .rx_rerr_other_in     (rx_rerr_other_in),
  .bist_activate_in     (bist_activate_in),
  .read_req_in          (read_req_in),
  .read_clear_in        (read_clear_in),
  .read_busy_out        (read_busy_out),
  .byte_valid_out       (byte_valid_out),
  .byte_ready_in        (byte_ready_in),
  .byte_data_out        (byte_data_out),
  .byte_last_out        (byte_last_out)
);

// *** pec_host_model.sv ***
`timescale 1ns/1ps
module pec_host_model (
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_b_in,
  // Stream control
  input wire logic        stall_in,
  input wire logic        byte_valid_in,
  input wire logic [7:0]  byte_data_in,
  input wire logic        byte_last_in,
  output logic            byte_ready_out,
  // Entries parsed from the last page
  output logic [2:0]      entries_out
);
  logic [8:0] pos_reg;
  logic [8:0] next_reg;
  logic [7:0] id_lo_reg;
  logic       done_reg;
  wire        take = byte_valid_in && byte_ready_out;
  // The host reads the whole page; stalls only pace it, they never skip a byte
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      byte_ready_out <= 1'b0;
    end else begin
      byte_ready_out <= !stall_in || $urandom_range(1, 0) == 1;
    end
  end
  // Walks entries in order, sized by id bits 14:12, up to the first zero id
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pos_reg     <= 9'h000;
      next_reg    <= 9'h004;
      id_lo_reg   <= 8'h00;
      done_reg    <= 1'b0;
      entries_out <= 3'h0;
    end else if (take) begin
      pos_reg <= byte_last_in ? 9'h000 : 9'(pos_reg + 9'h001);
      if (pos_reg == 9'h000) begin
        next_reg    <= 9'h004;
        done_reg    <= 1'b0;
        entries_out <= 3'h0;
      end else if (!done_reg && pos_reg == next_reg) begin
        id_lo_reg <= byte_data_in;
      end else if (!done_reg && pos_reg == 9'(next_reg + 9'h001)) begin
        if ({byte_data_in, id_lo_reg} == 16'h0000) begin
          done_reg <= 1'b1;
        end else begin
          entries_out <= 3'(entries_out + 3'h1);
          next_reg    <= 9'(next_reg + 9'h002 + {5'h00, byte_data_in[6:4], 1'b0});
        end
      end
    end
  end
endmodule : pec_host_model

// *** phy_event_counter_log_test.sv ***
`timescale 1ns/1ps
module phy_event_counter_log_test;
  logic       clk_sys_in = 1'b0;
  logic       rst_b_in = 1'b0;
  logic       link_up = 1'b0, sig_ok = 1'b0, crc_err = 1'b0, oth_err = 1'b0, bist = 1'b0;
  logic       req = 1'b0, clr = 1'b0, stall = 1'b0;
  logic       busy, valid, ready, last;
  logic [7:0] data;
  logic [2:0] entries;
  logic [7:0] ids[4] = '{8'h09, 8'h0A, 8'h0B, 8'h0D};
  logic [8:0] exp_q[$];
  logic [8:0] e;
  int         cnt[4] = '{0, 0, 0, 0};
  int         mismatches = 0;
  int         compares = 0;
  int         cyc = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  pec_log_page DUT (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .phy_link_up_state_in(link_up),
    .sig_fis_rok_in(sig_ok), .rx_rerr_crc_in(crc_err), .rx_rerr_other_in(oth_err),
    .bist_activate_in(bist), .read_req_in(req), .read_clear_in(clr), .read_busy_out(busy),
    .byte_valid_out(valid), .byte_ready_in(ready), .byte_data_out(data), .byte_last_out(last));
  pec_host_model HOST (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .stall_in(stall), .byte_valid_in(valid),
    .byte_data_in(data), .byte_last_in(last), .byte_ready_out(ready), .entries_out(entries));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // Watcher and hang guard
  // ----------------------------------------
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (rst_b_in && valid && ready) begin
      compares++;
      e = exp_q.size() ? exp_q.pop_front() : 9'h1XX;
      if ({last, data} !== e) begin
        mismatches++;
        $display("unexpected %0t byte %h, want %h", $time, {last, data}, e);
      end
    end
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic read_page(input logic c);
    logic [7:0] b, s;
    s = 8'h00;
    for (int i = 0; i < 511; i++) begin
      b = 8'h00;
      if (i >= 4 && i < 20) begin
        case (i % 4)
          0: b = ids[i/4-1];
          1: b = 8'h10;
          2: b = 8'(cnt[i/4-1]);
          default: b = cnt[i/4-1] == 255 ? 8'hFF : 8'h00;
        endcase
      end
      exp_q.push_back({1'b0, b});
      s = s + b;
    end
    exp_q.push_back({1'b1, 8'h00 - s});
    @(posedge clk_sys_in);
    req <= 1'b1;
    clr <= c;
    @(posedge clk_sys_in);
    req <= 1'b0;
    repeat (3000) begin
      #1;
      if (busy === 1'b0) break;
      @(posedge clk_sys_in);
    end
    compares++;
    if (exp_q.size() != 0 || busy !== 1'b0) begin
      mismatches++;
      $display("unexpected %0t page short by %0d bytes", $time, exp_q.size());
    end
    compares++;
    if (entries !== 3'h4) begin
      mismatches++;
      $display("unexpected %0t host parsed %0d entries", $time, entries);
    end
    if (c) cnt = '{0, 0, 0, 0};
  endtask : read_page
  task automatic pulse_events(input int n[4]);
    for (int k = 0; k < 600; k++) begin
      @(posedge clk_sys_in);
      link_up <= k < 2 * n[0] && k % 2 == 1;
      sig_ok <= k < n[1];
      crc_err <= k < n[2];
      oth_err <= k < n[3];
    end
    for (int i = 0; i < 4; i++) cnt[i] = cnt[i] + n[i] > 255 ? 255 : cnt[i] + n[i];
  endtask : pulse_events
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int r[4];
    void'($urandom(32'hdebd));
    repeat (12) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    read_page(1'b0);
    stall <= 1'b1;
    for (int i = 0; i < 4; i++) r[i] = $urandom_range(200, 1);
    pulse_events(r);
    read_page(1'b1);
    read_page(1'b0);
    pulse_events('{299, 299, 299, 299});
    read_page(1'b0);
    @(posedge clk_sys_in);
    bist <= 1'b1;
    @(posedge clk_sys_in);
    bist <= 1'b0;
    cnt = '{0, 0, 0, 0};
    read_page(1'b0);
    print_verdict();
  end
endmodule : phy_event_counter_log_test
